// File: rtl/long_multiply_and_block_store_exec.sv
// Purpose: Executes one instruction word held in a register: subtract with borrow,
//          signed long multiply (and accumulate), coprocessor store and block store.
// Assumes: Avalon-MM slave for software; memory and coprocessor logic on i_sys_clk.
// Notes:   Register banks are loaded over the bus; writes stall while busy.
// Overview of operation
// - Subtract with borrow sets N, Z, C as not-borrow, V as overflow.
// - Subtract into program counter with flag bit restores saved status atomically.
// - Bit 25 picks immediate or register second operand.
// - Each instruction executes only when its condition passes.
// - Multiply-accumulate adds 64-bit product to the high/low pair with carry.
// - Long multiply writes product high word and low word.
// - Long multiply flags: N from high bit 31, Z when both words zero.
// - Early termination is decided on the second multiply operand.
// - Coprocessor store writes words at ascending addresses until coprocessor finishes.
// - No accepting coprocessor raises the undefined instruction exception.
// - Core defines coprocessor bits 31..23, 21..16, 11..0 only.
// - Data abort leaves base as original or updated value, selectable.
// - Stores drop the two low address bits and never rotate data.
// - Misaligned start with alignment checking enabled raises alignment exception.
// - Block store scans list bits 0 to 15, ascending addresses by 4.
// - Block store updates base only with the writeback bit set.
// - Base listed with writeback or program counter store: value is implementation's.
// - User-bank block store stores user registers in ascending order.
// - User-bank block store still reads its base from the current bank.
//
// Local design decisions: the Avalon-MM interface to the registers and the register offsets.
`include "exec_consts.svh"
module long_multiply_and_block_store_exec (
  input  wire logic                  i_sys_clk,
  input  wire logic                  i_resetn,
  input  wire logic [`AVS_AW-1:0]    i_avs_address,
  input  wire logic                  i_avs_read,
  input  wire logic                  i_avs_write,
  input  wire logic [31:0]           i_avs_writedata,
  input  wire logic [3:0]            i_avs_byteenable,
  output logic      [31:0]           o_avs_readdata,
  output logic                       o_avs_waitrequest,
  output logic                       o_mem_write,
  output logic      [31:0]           o_mem_addr,
  output logic      [31:0]           o_mem_wdata,
  input  wire logic                  i_mem_waitrequest,
  input  wire logic                  i_mem_abort,
  output logic                       o_cp_req,
  output logic      [31:0]           o_cp_instr,
  input  wire logic                  i_cp_accept,
  output logic                       o_cp_ready,
  input  wire logic                  i_cp_valid,
  input  wire logic [31:0]           i_cp_data,
  input  wire logic                  i_cp_last
);
  import exec_pkg::*;

  exec_pkg::state_type state_r, state_nxt;
  op_type      op;
  logic [31:0] cur_regs [16];
  logic [31:0] usr_regs [16];
  logic [31:0] instr_r, psr_r, saved_psr_r, addr_r, wb_val_r, rd_mux;
  logic [3:1]  ctrl_r;
  logic [5:0]  stat_r;
  logic [15:0] list_r;
  logic        last_r, wb_en_r, usr_bank_r, rd_ack_r;
  logic        busy, bus_wr, go, cond_pass, n_f, z_f, c_f, v_f;
  logic [3:0]  base_ix, rd_i, opa_ix, opb_ix, nxt_ix;
  logic [31:0] base, op2, sub_res, blk_len, blk_start, blk_new, cp_off, cp_start, cp_new;
  logic [32:0] sub_sum;
  logic [4:0]  cnt;
  logic        misalign, mul_start, mul_done, accepted;
  logic [63:0] product, mul_res;
  logic        rf_we0, rf_we1, flag_we, psr_restore;
  logic [3:0]  rf_ix0, rf_ix1;
  logic [31:0] rf_d0, rf_d1;
  logic [3:0]  flag_val;
  logic        ev_done, ev_skip, ev_undef, ev_align, ev_abort;

  function automatic logic [31:0] be_merge(input logic [31:0] old_v, input logic [31:0] new_v,
                                           input logic [3:0] be);
    logic [31:0] r;
    r = old_v;
    for (int b = 0; b < 4; b++)
    begin
      if (be[b])
        r[8*b +: 8] = new_v[8*b +: 8];
    end
    return r;
  endfunction

  assign busy  = (state_r != S_IDLE);
  assign bus_wr = i_avs_write && !busy;
  assign go    = bus_wr && (i_avs_address == `OFS_CTRL) && i_avs_byteenable[0]
                 && i_avs_writedata[`CTRL_GO];
  assign {n_f, z_f, c_f, v_f} = psr_r[`PSR_N:`PSR_V];
  assign base_ix = instr_r[19:16];
  assign rd_i    = instr_r[15:12];
  assign opb_ix  = instr_r[11:8];
  assign opa_ix  = instr_r[3:0];

  // Avalon-MM slave: reads take one wait state, writes stall while an instruction runs.
  assign o_avs_waitrequest = (i_avs_read && !rd_ack_r) || (i_avs_write && busy);

  always_comb
  begin
    rd_mux = 32'h0;
    case (i_avs_address[7:6])
      `BANK_CUR: rd_mux = cur_regs[i_avs_address[5:2]];
      `BANK_USR: rd_mux = usr_regs[i_avs_address[5:2]];
      default:
      begin
        case (i_avs_address)
          `OFS_CTRL:    rd_mux = {28'h0, ctrl_r, 1'b0};
          `OFS_INSTR:   rd_mux = instr_r;
          `OFS_STAT:    rd_mux = {26'h0, stat_r[5:1], busy};
          `OFS_CUR_PSR: rd_mux = psr_r;
          `OFS_SAV_PSR: rd_mux = saved_psr_r;
          default:      rd_mux = 32'h0;
        endcase
      end
    endcase
  end

  always_ff @(posedge i_sys_clk or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      rd_ack_r       <= 1'b0;
      o_avs_readdata <= 32'h0;
    end
    else
    begin
      rd_ack_r <= i_avs_read && !rd_ack_r;
      if (i_avs_read && !rd_ack_r)
        o_avs_readdata <= rd_mux;
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      ctrl_r  <= `CTRL_RESET;
      instr_r <= 32'h0;
      saved_psr_r <= 32'h0;
    end
    else if (bus_wr)
    begin
      if (i_avs_address == `OFS_CTRL)
        ctrl_r <= i_avs_byteenable[0] ? i_avs_writedata[3:1] : ctrl_r;
      if (i_avs_address == `OFS_INSTR)
        instr_r <= be_merge(instr_r, i_avs_writedata, i_avs_byteenable);
      if (i_avs_address == `OFS_SAV_PSR)
        saved_psr_r <= be_merge(saved_psr_r, i_avs_writedata, i_avs_byteenable);
    end
  end

  always_comb
  begin
    case (instr_r[31:28])
      4'h0:    cond_pass = z_f;
      4'h1:    cond_pass = !z_f;
      4'h2:    cond_pass = c_f;
      4'h3:    cond_pass = !c_f;
      4'h4:    cond_pass = n_f;
      4'h5:    cond_pass = !n_f;
      4'h6:    cond_pass = v_f;
      4'h7:    cond_pass = !v_f;
      4'h8:    cond_pass = c_f && !z_f;
      4'h9:    cond_pass = !c_f || z_f;
      4'hA:    cond_pass = (n_f == v_f);
      4'hB:    cond_pass = (n_f != v_f);
      4'hC:    cond_pass = !z_f && (n_f == v_f);
      4'hD:    cond_pass = z_f || (n_f != v_f);
      4'hE:    cond_pass = 1'b1;
      default: cond_pass = 1'b0;
    endcase
  end

  always_comb
  begin
    op = OP_NONE;
    if (instr_r[27:23] == 5'h01 && instr_r[7:4] == 4'h9 && instr_r[22] && !instr_r[25])
      op = OP_MUL;
    else if (instr_r[27:26] == 2'h0 && instr_r[24:21] == 4'h6
             && !(!instr_r[25] && instr_r[7] && instr_r[4]))
      op = OP_SUBC;
    else if (instr_r[27:25] == 3'h6 && !instr_r[20])
      op = OP_CPST;
    else if (instr_r[27:25] == 3'h4 && !instr_r[20])
      op = OP_BLKST;
  end

  always_comb
  begin
    base = cur_regs[base_ix];
    if (instr_r[`IB_IMM])
      op2 = ({24'h0, instr_r[7:0]} >> {instr_r[11:8], 1'b0})
            | ({24'h0, instr_r[7:0]} << (6'd32 - {1'b0, instr_r[11:8], 1'b0}));
    else
      op2 = cur_regs[opa_ix];
    // Add of inverted operand yields not-borrow in the carry.
    sub_sum = {1'b0, base} + {1'b0, ~op2} + {32'h0, c_f};
    sub_res = sub_sum[31:0];
    cnt = 5'h0;
    for (int i = 0; i < 16; i++)
      cnt = cnt + {4'h0, instr_r[i]};
    blk_len = {25'h0, cnt, 2'b00};
    if (instr_r[`IB_UP])
    begin
      blk_start = instr_r[`IB_PRE] ? base + `WORD_STEP : base;
      blk_new   = base + blk_len;
    end
    else
    begin
      blk_start = instr_r[`IB_PRE] ? base - blk_len : base - blk_len + `WORD_STEP;
      blk_new   = base - blk_len;
    end
    cp_off   = {22'h0, instr_r[7:0], 2'b00};
    cp_new   = instr_r[`IB_UP] ? base + cp_off : base - cp_off;
    cp_start = instr_r[`IB_PRE] ? cp_new : base;
    misalign = ctrl_r[`CTRL_SCC_PRESENT] && ctrl_r[`CTRL_ALIGN_EN]
               && (((op == OP_BLKST) ? blk_start[1:0] : cp_start[1:0]) != 2'b00);
  end

  assign mul_start = (state_r == S_EXEC) && cond_pass && (op == OP_MUL);

  long_mul_iter u_mul (
    .i_sys_clk (i_sys_clk),
    .i_resetn  (i_resetn),
    .i_start   (mul_start),
    .i_op_a    (cur_regs[opa_ix]),
    .i_op_b    (cur_regs[opb_ix]),
    .o_done    (mul_done),
    .o_product (product)
  );

  // Accumulate as one 64-bit add so the low carry reaches the high word.
  assign mul_res = instr_r[`IB_ACC] ? product + {cur_regs[base_ix], cur_regs[rd_i]} : product;

  // Lowest listed register still to be stored.
  always_comb
  begin
    nxt_ix = 4'h0;
    for (int i = 15; i >= 0; i--)
    begin
      if (list_r[i])
        nxt_ix = i[3:0];
    end
  end

  assign accepted   = o_mem_write && !i_mem_waitrequest;
  assign o_cp_req   = (state_r == S_CP_ASK);
  assign o_cp_ready = (state_r == S_CP_GET);
  // Whole word passed on; bits 22 and 15..12 belong to the coprocessor.
  assign o_cp_instr = instr_r;

  always_comb
  begin
    state_nxt = state_r;
    {rf_we0, rf_we1, flag_we, psr_restore} = 4'h0;
    {rf_ix0, rf_ix1, flag_val} = 12'h0;
    rf_d0 = 32'h0;
    rf_d1 = 32'h0;
    {ev_done, ev_skip, ev_undef, ev_align, ev_abort} = 5'h0;
    case (state_r)
      S_IDLE:
        if (go)
          state_nxt = S_EXEC;
      S_EXEC:
      begin
        state_nxt = S_IDLE;
        ev_done = 1'b1;
        if (!cond_pass)
          ev_skip = 1'b1;
        else
        begin
          case (op)
            OP_SUBC:
            begin
              rf_we0 = 1'b1;
              rf_ix0 = rd_i;
              rf_d0  = sub_res;
              if (instr_r[`IB_SFLAG] && rd_i == `PC_IDX)
                psr_restore = 1'b1;
              else if (instr_r[`IB_SFLAG])
              begin
                flag_we  = 1'b1;
                flag_val = {sub_res[31], sub_res == 32'h0, sub_sum[32],
                            (base[31] != op2[31]) && (sub_res[31] != base[31])};
              end
            end
            OP_MUL:
            begin
              state_nxt = S_MUL;
              ev_done = 1'b0;
            end
            OP_BLKST, OP_CPST:
            begin
              if (misalign)
                ev_align = 1'b1;
              else
              begin
                state_nxt = (op == OP_BLKST) ? S_PUT : S_CP_ASK;
                ev_done = 1'b0;
              end
            end
            default:
              ev_undef = 1'b1;
          endcase
        end
      end
      S_MUL:
        if (mul_done)
        begin
          {rf_we0, rf_we1} = 2'b11;
          {rf_ix0, rf_ix1} = {rd_i, base_ix};
          {rf_d1, rf_d0}   = mul_res;
          flag_we  = instr_r[`IB_SFLAG];
          flag_val = {mul_res[63], mul_res == 64'h0, c_f, v_f};
          ev_done   = 1'b1;
          state_nxt = S_IDLE;
        end
      S_CP_ASK:
      begin
        state_nxt = S_CP_GET;
        if (!i_cp_accept)
        begin
          ev_undef  = 1'b1;
          ev_done   = 1'b1;
          state_nxt = S_IDLE;
        end
      end
      S_CP_GET:
        if (i_cp_valid)
          state_nxt = S_PUT;
      S_PUT:
        if (accepted)
        begin
          if (i_mem_abort || last_r)
          begin
            rf_we0    = wb_en_r && !(i_mem_abort && ctrl_r[`CTRL_ABORT_KEEP]);
            rf_ix0    = base_ix;
            rf_d0     = wb_val_r;
            ev_abort  = i_mem_abort;
            ev_done   = 1'b1;
            state_nxt = S_IDLE;
          end
          else if (instr_r[27:25] == 3'h6)
            state_nxt = S_CP_GET;
        end
      default:
        state_nxt = S_IDLE;
    endcase
  end

  always_ff @(posedge i_sys_clk or negedge i_resetn)
  begin
    if (!i_resetn)
      state_r <= S_IDLE;
    else
      state_r <= state_nxt;
  end

  // Memory write port and transfer bookkeeping.
  always_ff @(posedge i_sys_clk or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      {o_mem_write, last_r, wb_en_r, usr_bank_r} <= 4'h0;
      {o_mem_addr, o_mem_wdata, addr_r, wb_val_r} <= 128'h0;
      list_r <= 16'h0;
    end
    else
    begin
      if (state_r == S_EXEC)
      begin
        addr_r     <= (op == OP_BLKST) ? blk_start : cp_start;
        wb_val_r   <= (op == OP_BLKST) ? blk_new : cp_new;
        wb_en_r    <= instr_r[`IB_WB];
        list_r     <= instr_r[15:0];
        // Writeback here is left to software to avoid.
        usr_bank_r <= instr_r[`IB_USRBANK];
        last_r     <= 1'b0;
      end
      if (accepted)
        o_mem_write <= 1'b0;
      // Listed base or program counter stores its unmodified value from the selected bank (user bank when bit 22 is set).
      if ((state_nxt == S_PUT) && (op == OP_BLKST || state_r == S_PUT) && !o_mem_write
          && instr_r[27:25] == 3'h4 && list_r != 16'h0 && state_r != S_EXEC)
      begin
        o_mem_write <= 1'b1;
        o_mem_addr  <= {addr_r[31:2], 2'b00};
        o_mem_wdata <= usr_bank_r ? usr_regs[nxt_ix] : cur_regs[nxt_ix];
        addr_r      <= addr_r + `WORD_STEP;
        list_r      <= list_r & ~(16'h1 << nxt_ix);
        last_r      <= ((list_r & ~(16'h1 << nxt_ix)) == 16'h0);
      end
      if (state_r == S_CP_GET && i_cp_valid)
      begin
        o_mem_write <= 1'b1;
        o_mem_addr  <= {addr_r[31:2], 2'b00};
        o_mem_wdata <= i_cp_data;
        addr_r      <= addr_r + `WORD_STEP;
        last_r      <= i_cp_last;
      end
    end
  end

  // Register banks; the bus writes only while idle.
  always_ff @(posedge i_sys_clk or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      for (int i = 0; i < 16; i++)
      begin
        cur_regs[i] <= 32'h0;
        usr_regs[i] <= 32'h0;
      end
    end
    else
    begin
      if (bus_wr && i_avs_address[7:6] == `BANK_CUR)
        cur_regs[i_avs_address[5:2]] <= be_merge(cur_regs[i_avs_address[5:2]],
                                                 i_avs_writedata, i_avs_byteenable);
      if (bus_wr && i_avs_address[7:6] == `BANK_USR)
        usr_regs[i_avs_address[5:2]] <= be_merge(usr_regs[i_avs_address[5:2]],
                                                 i_avs_writedata, i_avs_byteenable);
      if (rf_we1)
        cur_regs[rf_ix1] <= rf_d1;
      if (rf_we0)
        cur_regs[rf_ix0] <= rf_d0;
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_resetn)
  begin
    if (!i_resetn)
      psr_r <= `PSR_RESET;
    else if (bus_wr && i_avs_address == `OFS_CUR_PSR)
      psr_r <= be_merge(psr_r, i_avs_writedata, i_avs_byteenable);
    else if (psr_restore)
      psr_r <= saved_psr_r;
    else if (flag_we)
      psr_r[`PSR_N:`PSR_V] <= flag_val;
  end

  // Sticky outcome bits, cleared when a new instruction starts.
  always_ff @(posedge i_sys_clk or negedge i_resetn)
  begin
    if (!i_resetn)
      stat_r <= 6'h0;
    else if (go)
      stat_r <= 6'h0;
    else
      stat_r <= stat_r | {ev_abort, ev_align, ev_undef, ev_skip, ev_done, 1'b0};
  end
endmodule // long_multiply_and_block_store_exec

// File: rtl/exec_consts.svh
// Purpose: Offsets, field positions, reset values and steps of the execution block.
// Assumes: Byte addresses on a 32-bit Avalon-MM slave, one register per word.
// Notes:   Included by the package and the design files.
`ifndef EXEC_CONSTS_SVH
`define EXEC_CONSTS_SVH
`define AVS_AW           8
`define OFS_CTRL         8'h00
`define OFS_INSTR        8'h04
`define OFS_STAT         8'h08
`define OFS_CUR_PSR      8'h0C
`define OFS_SAV_PSR      8'h10
`define BANK_CUR         2'h1
`define BANK_USR         2'h2
`define CTRL_GO          0
`define CTRL_ALIGN_EN    1
`define CTRL_SCC_PRESENT 2
`define CTRL_ABORT_KEEP  3
`define CTRL_RESET       3'h0
`define ST_BUSY          0
`define ST_DONE          1
`define ST_SKIP          2
`define ST_UNDEF         3
`define ST_ALIGN         4
`define ST_ABORT         5
`define PSR_N            31
`define PSR_V            28
`define PSR_RESET        32'h0000001F
`define MODE_USR         5'h10
`define MODE_SYS         5'h1F
`define PC_IDX           4'hF
`define WORD_STEP        32'h00000004
`define IB_IMM           25
`define IB_PRE           24
`define IB_UP            23
`define IB_USRBANK       22
`define IB_WB            21
`define IB_ACC           21
`define IB_SFLAG         20
`endif

// File: rtl/exec_pkg.sv
// Purpose: Types shared by the execution block.
// Assumes: Constants come from exec_consts.svh.
// Notes:   States and operation kinds carry no fixed codes.
`include "exec_consts.svh"
package exec_pkg;
  typedef enum logic [2:0] {S_IDLE, S_EXEC, S_MUL, S_CP_ASK, S_CP_GET, S_PUT} state_type;
  typedef enum logic [2:0] {OP_NONE, OP_SUBC, OP_MUL, OP_CPST, OP_BLKST} op_type;
endpackage

// File: rtl/long_mul_iter.sv
// Purpose: Iterative signed 32x32 to 64-bit multiplier, one multiplier byte per cycle.
// Assumes: i_start is a one-cycle pulse; operands are stable at that edge.
// Notes:   Finishes after 1 to 4 cycles depending on the multiplier operand.
module long_mul_iter (
  input  wire logic        i_sys_clk,
  input  wire logic        i_resetn,
  input  wire logic        i_start,
  input  wire logic [31:0] i_op_a,
  input  wire logic [31:0] i_op_b,
  output logic             o_done,
  output logic [63:0]      o_product
);
  logic signed [63:0] acc_r;
  logic signed [63:0] mcand_r;
  logic signed [31:0] mplr_r;
  logic               run_r;
  logic signed [63:0] part;
  logic signed [63:0] sum;
  logic signed [63:0] mcand_nxt;
  logic signed [31:0] rest;
  logic               fin;

  always_comb
  begin
    part      = mcand_r * $signed({56'h0, mplr_r[7:0]});
    sum       = acc_r + part;
    mcand_nxt = mcand_r <<< 8;
    rest      = mplr_r >>> 8;
    // Stop on multiplier.
    // The remaining multiplier bits are pure sign, so signed early termination applies.
    fin       = (rest == 32'h00000000) || (rest == 32'hFFFFFFFF);
  end

  always_ff @(posedge i_sys_clk or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      acc_r     <= 64'h0;
      mcand_r   <= 64'h0;
      mplr_r    <= 32'h0;
      run_r     <= 1'b0;
      o_done    <= 1'b0;
      o_product <= 64'h0;
    end
    else
    begin
      o_done <= 1'b0;
      if (i_start)
      begin
        acc_r   <= 64'h0;
        mcand_r <= {{32{i_op_a[31]}}, i_op_a};
        mplr_r  <= i_op_b;
        run_r   <= 1'b1;
      end
      else if (run_r)
      begin
        if (fin)
        begin
          o_product <= rest[31] ? (sum - mcand_nxt) : sum;
          run_r     <= 1'b0;
          o_done    <= 1'b1;
        end
        else
        begin
          acc_r   <= sum;
          mcand_r <= mcand_nxt;
          mplr_r  <= rest;
        end
      end
    end
  end
endmodule // long_mul_iter

// File: verification/exec_partner.sv
// Purpose: Memory system and coprocessor model facing the execution block.
// Assumes: Same clock as the block; i_clr empties the store log.
// Notes:   i_slow stalls every other cycle; abort hits store number i_abort_idx.
module exec_partner (
  input  wire logic        i_sys_clk, i_resetn, i_clr, i_slow, i_accept_en,
  input  wire logic        i_mem_write, i_cp_req, i_cp_ready,
  input  wire logic [31:0] i_mem_addr, i_mem_wdata,
  input  wire logic [3:0]  i_nwords, i_abort_idx,
  output logic             o_mem_waitrequest, o_mem_abort, o_cp_accept,
  output logic             o_cp_valid, o_cp_last,
  output logic [31:0]      o_cp_data
);
  timeunit 1ns / 1ps;
  logic [3:0]  cnt_r, wcnt_r;
  logic        tog_r;
  logic [31:0] st_addr [$];
  logic [31:0] st_data [$];
  assign o_mem_waitrequest = i_slow & tog_r;
  assign o_mem_abort = i_mem_write & (cnt_r == i_abort_idx);
  assign o_cp_accept = i_cp_req & i_accept_en;
  assign o_cp_valid = i_cp_ready & ~(i_slow & tog_r);
  assign o_cp_last = (wcnt_r == i_nwords - 4'h1);
  assign o_cp_data = o_cp_valid ? {28'hC0DE000, wcnt_r} : ~{28'hC0DE000, wcnt_r};
  always @(posedge i_sys_clk or negedge i_resetn)
    if (!i_resetn)
    begin
      tog_r <= 1'b0;
      {cnt_r, wcnt_r} <= 8'h0;
    end
    else
    begin
      tog_r <= ~tog_r;
      if (i_clr)
      begin
        {cnt_r, wcnt_r} <= 8'h0;
        st_addr.delete();
        st_data.delete();
      end
      else
      begin
        if (i_mem_write && !o_mem_waitrequest)
        begin
          cnt_r <= cnt_r + 4'h1;
          st_addr.push_back(i_mem_addr);
          st_data.push_back(i_mem_wdata);
        end
        if (o_cp_valid)
          wcnt_r <= wcnt_r + 4'h1;
      end
    end
endmodule // exec_partner

// File: verification/long_multiply_and_block_store_exec_asserts.sv
// Purpose: Port checks of the store and coprocessor paths.
// Assumes: One clock, asynchronous active-low reset.
// Notes:   Bound to the block below.
module exec_checker (
  input wire logic        i_sys_clk, i_resetn, i_avs_write,
  input wire logic        o_mem_write, i_mem_waitrequest, i_mem_abort,
  input wire logic        o_cp_req, i_cp_accept, o_cp_ready, i_cp_valid, i_cp_last,
  input wire logic [31:0] o_mem_addr, o_mem_wdata, i_cp_data
);
  timeunit 1ns / 1ps;
  default clocking dcb @(posedge i_sys_clk); endclocking
  default disable iff (!i_resetn);
  logic        seen_r, fin_r;
  logic [31:0] prev_r;
  wire         acc = o_mem_write & ~i_mem_waitrequest;
  always_ff @(posedge i_sys_clk or negedge i_resetn)
    if (!i_resetn) seen_r <= 1'b0;
    else if (i_avs_write) seen_r <= 1'b0;
    else if (acc) seen_r <= 1'b1;
  always_ff @(posedge i_sys_clk or negedge i_resetn)
    if (!i_resetn) prev_r <= 32'h0;
    else if (acc) prev_r <= o_mem_addr;
  always_ff @(posedge i_sys_clk or negedge i_resetn)
    if (!i_resetn) fin_r <= 1'b0;
    else if (i_avs_write) fin_r <= 1'b0;
    else if (o_cp_ready && i_cp_valid && i_cp_last) fin_r <= 1'b1;
  AST_WORD_ADDR: assert property (o_mem_write |-> o_mem_addr[1:0] == 2'h0)
    else $error("store address not word aligned");
  AST_HOLD: assert property (o_mem_write && i_mem_waitrequest |=> o_mem_write
    && $stable(o_mem_addr) && $stable(o_mem_wdata)) else $error("store dropped while stalled");
  AST_ASCEND: assert property ($rose(o_mem_write) && seen_r |->
    o_mem_addr == prev_r + 32'h4) else $error("store address not previous plus four");
  AST_REQ_PULSE: assert property (o_cp_req |=> !o_cp_req)
    else $error("coprocessor request held");
  AST_UNDEF: assert property (o_cp_req && !i_cp_accept |=>
    (!o_mem_write && !o_cp_ready) [*4]) else $error("transfer after refusal");
  AST_CP_WORD: assert property (o_cp_ready && i_cp_valid |=>
    o_mem_write && o_mem_wdata == $past(i_cp_data)) else $error("word not stored");
  AST_LAST: assert property (fin_r && acc |=> (!o_cp_ready && !o_mem_write) [*3])
    else $error("transfer after final word");
  AST_ABORT: assert property (acc && i_mem_abort |=> (!o_mem_write && !o_cp_ready) [*3])
    else $error("store after abort");
  cover property (acc && i_mem_abort);
  cover property (o_cp_req && !i_cp_accept);
  cover property (fin_r && acc);
endmodule // exec_checker
bind long_multiply_and_block_store_exec exec_checker i_chk (.i_sys_clk, .i_resetn,
  .i_avs_write, .o_mem_write, .i_mem_waitrequest, .i_mem_abort, .o_cp_req, .i_cp_accept,
  .o_cp_ready, .i_cp_valid, .i_cp_last, .o_mem_addr, .o_mem_wdata, .i_cp_data);

// File: verification/long_multiply_and_block_store_exec_tb.sv
// Purpose: Self-checking bench of the execution block.
// Assumes: Partner model logs every accepted store.
// Notes:   Status is judged on bits 5..2 only.
module long_multiply_and_block_store_exec_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk = 1'b0, rstn = 1'b0, rd = 1'b0, wr = 1'b0;
  logic        slow = 1'b0, acc_en = 1'b1, clr = 1'b0;
  logic [7:0]  adr = 8'h00;
  logic [3:0]  nw = 4'h3, abi = 4'hF;
  logic [31:0] wd = 32'h0, rdat, maddr, mwd, cins, cdat, q;
  logic        wt, mwr, mwt, mab, creq, cacc, crdy, cval, clast;
  int          errors = 0, total_checks = 0;
  always #4 clk = ~clk;
  long_multiply_and_block_store_exec i_dut (.i_sys_clk(clk), .i_resetn(rstn),
    .i_avs_address(adr), .i_avs_read(rd), .i_avs_write(wr), .i_avs_writedata(wd),
    .i_avs_byteenable(4'hF), .o_avs_readdata(rdat), .o_avs_waitrequest(wt),
    .o_mem_write(mwr), .o_mem_addr(maddr), .o_mem_wdata(mwd), .i_mem_waitrequest(mwt),
    .i_mem_abort(mab), .o_cp_req(creq), .o_cp_instr(cins), .i_cp_accept(cacc),
    .o_cp_ready(crdy), .i_cp_valid(cval), .i_cp_data(cdat), .i_cp_last(clast));
  exec_partner i_part (.i_sys_clk(clk), .i_resetn(rstn), .i_clr(clr), .i_slow(slow),
    .i_accept_en(acc_en), .i_mem_write(mwr), .i_cp_req(creq), .i_cp_ready(crdy),
    .i_mem_addr(maddr), .i_mem_wdata(mwd), .i_nwords(nw), .i_abort_idx(abi),
    .o_mem_waitrequest(mwt), .o_mem_abort(mab), .o_cp_accept(cacc), .o_cp_valid(cval),
    .o_cp_last(clast), .o_cp_data(cdat));
  task automatic end_sim;
    $display("checks %0d errors %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      errors++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    adr <= a;
    wd <= d;
    wr <= w;
    rd <= ~w;
    @(posedge clk iff !wt);
    q = rdat;
    wr <= 1'b0;
    rd <= 1'b0;
    @(posedge clk);
  endtask
  task automatic rchk(input logic [7:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    chk(q, e);
  endtask
  task automatic run(input logic [31:0] ins, input logic [3:0] ctl, input logic [31:0] st);
    clr <= 1'b1;
    bus(1'b1, 8'h04, ins);
    clr <= 1'b0;
    bus(1'b1, 8'h00, {28'h0, ctl});
    do bus(1'b0, 8'h08, 32'h0); while (q[0] !== 1'b0);
    chk(q & 32'h3C, st);
  endtask
  task automatic stores(input int n, input logic [31:0] a0);
    chk(i_part.st_addr.size(), n);
    for (int k = 0; k < n; k++)
      chk(i_part.st_addr[k], a0 + 32'(4 * k));
  endtask
  task automatic t_sub;
    bus(1'b1, 8'h44, 32'h5);
    bus(1'b1, 8'h48, 32'h7);
    bus(1'b1, 8'h0C, 32'h1F);
    run(32'hE0D13002, 4'h1, 32'h0);
    rchk(8'h4C, 32'hFFFFFFFD);
    rchk(8'h0C, 32'h8000001F);
    bus(1'b1, 8'h0C, 32'h2000001F);
    run(32'hE2D14005, 4'h1, 32'h0);
    rchk(8'h0C, 32'h6000001F);
    run(32'h10D15002, 4'h1, 32'h4);
    rchk(8'h54, 32'h0);
    rchk(8'h0C, 32'h6000001F);
  endtask
  task automatic t_pc;
    bus(1'b1, 8'h0C, 32'h60000013);
    bus(1'b1, 8'h10, 32'h90000010);
    run(32'hE2D1F002, 4'h1, 32'h0);
    rchk(8'h7C, 32'h3);
    rchk(8'h0C, 32'h90000010);
  endtask
  task automatic t_mul;
    logic [31:0] ins [3] = '{32'hE0D43291, 32'hE0F43291, 32'hE0D43091};
    logic [31:0] lo [3] = '{32'hFFFDFFFA, 32'hFFFBFFF4, 32'h0};
    logic [31:0] hi [3] = '{32'hFFFFFFFF, 32'hFFFFFFFF, 32'h0};
    logic [31:0] ps [3] = '{32'hA0000013, 32'hA0000013, 32'h60000013};
    bus(1'b1, 8'h0C, 32'h20000013);
    bus(1'b1, 8'h44, 32'hFFFFFFFE);
    bus(1'b1, 8'h48, 32'h00010003);
    for (int i = 0; i < 3; i++)
    begin
      run(ins[i], 4'h1, 32'h0);
      rchk(8'h4C, lo[i]);
      rchk(8'h50, hi[i]);
      rchk(8'h0C, ps[i]);
    end
  endtask
  task automatic t_block;
    logic [31:0] dat [3] = '{32'hFFFFFFFE, 32'h00010003, 32'h3};
    slow <= 1'b1;
    bus(1'b1, 8'h74, 32'h1000);
    run(32'hE88D8006, 4'h1, 32'h0);
    rchk(8'h74, 32'h1000);
    run(32'hE8AD8006, 4'h1, 32'h0);
    stores(3, 32'h1000);
    for (int k = 0; k < 3; k++)
      chk(i_part.st_data[k], dat[k]);
    rchk(8'h74, 32'h100C);
    abi <= 4'h1;
    run(32'hE8AD8006, 4'h9, 32'h20);
    stores(2, 32'h100C);
    rchk(8'h74, 32'h100C);
    abi <= 4'hF;
    bus(1'b1, 8'h74, 32'h1002);
    run(32'hE88D8006, 4'h7, 32'h10);
    stores(0, 32'h0);
    run(32'hE88D8006, 4'h1, 32'h0);
    stores(3, 32'h1000);
    bus(1'b1, 8'h84, 32'hAAAA);
    run(32'hE8CD0002, 4'h1, 32'h0);
    stores(1, 32'h1000);
    chk(i_part.st_data[0], 32'hAAAA);
  endtask
  task automatic t_cop;
    logic [31:0] ins [2] = '{32'hED8D0100, 32'hEDCD0100};
    for (int i = 0; i < 2; i++)
    begin
      nw <= 4'(2 + i);
      run(ins[i], 4'h1, 32'h0);
      chk(cins, ins[i]);
      stores(2 + i, 32'h1000);
      for (int k = 0; k < 2 + i; k++)
        chk(i_part.st_data[k], 32'hC0DE0000 + 32'(k));
    end
    acc_en <= 1'b0;
    run(ins[0], 4'h1, 32'h8);
    stores(0, 32'h0);
  endtask
  initial
  begin
    repeat (20000) @(posedge clk);
    errors++;
    end_sim;
  end
  initial
  begin
    repeat (8) @(posedge clk);
    rstn <= 1'b1;
    @(posedge clk);
    t_sub;
    t_pc;
    t_mul;
    t_block;
    t_cop;
    end_sim;
  end
endmodule // long_multiply_and_block_store_exec_tb
